/* File: adcsp_defs.svh */
`ifndef ADCSP_DEFS_SVH
`define ADCSP_DEFS_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define ADCSP_FRAME_BITS   16
`define ADCSP_RESULT_BITS  12
`define ADCSP_CTL_BITS     5
`define ADCSP_CTL_LOAD_IDX 3'h5
`define ADCSP_CTL_DONE_IDX 3'h6
`define ADCSP_CTL_RESET    5'h00
`define ADCSP_CHAN_MSB     4
`define ADCSP_CHAN_LSB     2
`define ADCSP_START_BIT    1
`define ADCSP_STBY_BIT     0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ADCSP_CLK_HZ       40000000
`define ADCSP_SCLK_MAX_HZ  2500000
`define ADCSP_SCLK_HALF    ((`ADCSP_CLK_HZ + 2 * `ADCSP_SCLK_MAX_HZ - 1) / (2 * `ADCSP_SCLK_MAX_HZ))
`define ADCSP_SCLK_TOGGLES 32
`define ADCSP_FIFO_DEPTH   4

`endif

/* File: adcsp_pkg.sv */
package adcsp_pkg;
	typedef enum logic [1:0]
	{
		ADCSP_GEN_IDLE = 2'b01,
		ADCSP_GEN_RUN  = 2'b10
	} adcsp_gen_e;
endpackage

/* File: adcsp_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adcsp_defs.svh"

// ----------------------------------------------------------------
// result buffer
// ----------------------------------------------------------------
module adcsp_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic             wr_valid_in,
	output var  logic             wr_ready_out,
	output var  logic [WIDTH-1:0] rd_data_out,
	output var  logic             rd_valid_out,
	input  wire logic             rd_ready_in
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wp_q;
	logic [AW-1:0]    rp_q;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             push;
	logic             pop;

	assign push         = wr_valid_in & wr_ready_out;
	assign pop          = rd_valid_out & rd_ready_in;
	assign rd_valid_out = (cnt_q != '0);
	assign rd_data_out  = mem_q[rp_q];

	always_comb
	begin
		cnt_d = cnt_q;
		if (push && !pop)
			cnt_d = cnt_q + 1'b1;
		else if (pop && !push)
			cnt_d = cnt_q - 1'b1;
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			cnt_q        <= '0;
			wr_ready_out <= 1'b0;
		end
		else
		begin
			cnt_q        <= cnt_d;
			wr_ready_out <= (cnt_d != (AW+1)'(DEPTH));
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			wp_q <= '0;
			rp_q <= '0;
		end
		else
		begin
			if (push)
				wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
			if (pop)
				rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (push)
			mem_q[wp_q] <= wr_data_in;
	end
endmodule

// ----------------------------------------------------------------
// shared-frame serial port
// ----------------------------------------------------------------
module adcsp_port
	import adcsp_pkg::*;
#(
	parameter int FIFO_DEPTH = `ADCSP_FIFO_DEPTH
) (
	// system
	input  wire logic        clk_sys_in,
	input  wire logic        reset_in,
	// link clock, the resolved serial clock wire
	input  wire logic        link_clk_in,
	// serial pins
	input  wire logic        clock_source_select_in,
	output var  logic        sclk_out,
	output var  logic        sclk_oe_out,
	input  wire logic        receive_frame_n_in,
	output var  logic        receive_frame_n_out,
	output var  logic        receive_frame_n_oe_out,
	input  wire logic        transmit_frame_n_in,
	input  wire logic        data_in,
	output var  logic        data_out,
	output var  logic        data_oe_out,
	input  wire logic        sample_trigger_n_in,
	// conversion results
	input  wire logic [11:0] result_data_in,
	input  wire logic        result_valid_in,
	output var  logic        result_ready_out,
	// control outputs
	output var  logic [2:0]  channel_out,
	output var  logic        standby_out,
	output var  logic        sw_convert_out,
	output var  logic        hw_convert_out,
	output var  logic        self_clocking_out
);
	// ------------------------------------------------------------
	// link domain
	// ------------------------------------------------------------
	logic        lrst_m_q;
	logic        lrst_q;
	logic [4:0]  pcnt_q;
	logic [15:0] sh_q;
	logic        ack_t_q;
	logic [2:0]  fcnt_q;
	logic [4:0]  wsh_q;
	logic [4:0]  ctl_q;
	logic        ctl_t_q;
	logic [11:0] word_q;
	logic        word_valid_q;

	always_ff @(posedge link_clk_in)
	begin
		lrst_m_q <= reset_in;
		lrst_q   <= lrst_m_q;
	end

	// frame rise ends the read at once, even with the clock stopped
	always_ff @(posedge link_clk_in or posedge receive_frame_n_in)
	begin
		if (receive_frame_n_in)
		begin
			pcnt_q      <= 5'h00;
			data_oe_out <= 1'b0;
		end
		else if (lrst_q)
		begin
			pcnt_q      <= 5'h00;
			data_oe_out <= 1'b0;
		end
		else if (pcnt_q < 5'(`ADCSP_FRAME_BITS))
		begin
			pcnt_q      <= pcnt_q + 5'h01;
			data_oe_out <= 1'b1;
		end
		else
			data_oe_out <= 1'b0;
	end

	// shifted out on rising edges, sampled by the host on falling ones
	always_ff @(posedge link_clk_in)
	begin
		if (lrst_q)
		begin
			sh_q     <= 16'h0000;
			data_out <= 1'b0;
			ack_t_q  <= 1'b0;
		end
		else if (!receive_frame_n_in && pcnt_q == 5'h00)
		begin
			sh_q     <= {ctl_q[`ADCSP_CHAN_MSB:`ADCSP_CHAN_LSB], word_q, 1'b0};
			data_out <= 1'b0;
			ack_t_q  <= ~ack_t_q;
		end
		else if (!receive_frame_n_in)
		begin
			data_out <= sh_q[15];
			sh_q     <= {sh_q[14:0], 1'b0};
		end
	end

	// control word captured on falling edges
	always_ff @(negedge link_clk_in or posedge transmit_frame_n_in)
	begin
		if (transmit_frame_n_in)
			fcnt_q <= 3'h0;
		else if (lrst_q)
			fcnt_q <= 3'h0;
		else if (fcnt_q != `ADCSP_CTL_DONE_IDX)
			fcnt_q <= fcnt_q + 3'h1;
	end

	always_ff @(negedge link_clk_in)
	begin
		if (lrst_q)
		begin
			wsh_q   <= `ADCSP_CTL_RESET;
			ctl_q   <= `ADCSP_CTL_RESET;
			ctl_t_q <= 1'b0;
		end
		else if (!transmit_frame_n_in)
		begin
			if (fcnt_q < `ADCSP_CTL_LOAD_IDX)
				wsh_q <= {wsh_q[3:0], data_in};
			if (fcnt_q == `ADCSP_CTL_LOAD_IDX)
			begin
				ctl_q   <= wsh_q;
				ctl_t_q <= ~ctl_t_q;
			end
		end
	end

	// ------------------------------------------------------------
	// system domain crossings
	// ------------------------------------------------------------
	logic [1:0] ss_q;
	logic [2:0] tr_q;
	logic [2:0] ct_q;
	logic [2:0] ak_q;
	logic       ack_ev;
	logic       ctl_ev;

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			ss_q <= 2'h3;
			tr_q <= 3'h7;
			ct_q <= 3'h0;
			ak_q <= 3'h0;
		end
		else
		begin
			ss_q <= {ss_q[0], clock_source_select_in};
			tr_q <= {tr_q[1:0], sample_trigger_n_in};
			ct_q <= {ct_q[1:0], ctl_t_q};
			ak_q <= {ak_q[1:0], ack_t_q};
		end
	end

	assign ack_ev = ak_q[2] ^ ak_q[1];
	assign ctl_ev = ct_q[2] ^ ct_q[1];

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			channel_out       <= 3'h0;
			standby_out       <= 1'b0;
			sw_convert_out    <= 1'b0;
			hw_convert_out    <= 1'b0;
			self_clocking_out <= 1'b0;
		end
		else
		begin
			self_clocking_out <= ~ss_q[1];
			hw_convert_out    <= tr_q[1] & ~tr_q[2];
			sw_convert_out    <= ctl_ev & ctl_q[`ADCSP_START_BIT];
			if (ctl_ev)
			begin
				channel_out <= ctl_q[`ADCSP_CHAN_MSB:`ADCSP_CHAN_LSB];
				standby_out <= ctl_q[`ADCSP_STBY_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// result staging
	// ------------------------------------------------------------
	logic [11:0] fifo_data;
	logic        fifo_valid;

	adcsp_fifo #(
		.WIDTH (`ADCSP_RESULT_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in       (clk_sys_in),
		.reset_in     (reset_in),
		.wr_data_in   (result_data_in),
		.wr_valid_in  (result_valid_in),
		.wr_ready_out (result_ready_out),
		.rd_data_out  (fifo_data),
		.rd_valid_out (fifo_valid),
		.rd_ready_in  (~word_valid_q)
	);

	// word stays still while valid, so the link reads it safely
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			word_q       <= 12'h000;
			word_valid_q <= 1'b0;
		end
		else if (!word_valid_q && fifo_valid)
		begin
			word_q       <= fifo_data;
			word_valid_q <= 1'b1;
		end
		else if (ack_ev)
			word_valid_q <= 1'b0;
	end

	// ------------------------------------------------------------
	// self-clocking frame and clock generator
	// ------------------------------------------------------------
	adcsp_gen_e gen_q;
	logic [3:0] div_q;
	logic [5:0] tog_q;

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			gen_q               <= ADCSP_GEN_IDLE;
			div_q               <= 4'h0;
			tog_q               <= 6'h00;
			sclk_out            <= 1'b0;
			receive_frame_n_out <= 1'b1;
		end
		else
		begin
			unique case (gen_q)
				ADCSP_GEN_IDLE:
				begin
					sclk_out <= 1'b0;
					div_q    <= 4'h0;
					tog_q    <= 6'h00;
					if (!ss_q[1] && word_valid_q)
					begin
						gen_q               <= ADCSP_GEN_RUN;
						receive_frame_n_out <= 1'b0;
					end
				end
				ADCSP_GEN_RUN:
				begin
					if (div_q == 4'(`ADCSP_SCLK_HALF - 1))
					begin
						div_q <= 4'h0;
						if (tog_q == 6'(`ADCSP_SCLK_TOGGLES))
						begin
							gen_q               <= ADCSP_GEN_IDLE;
							receive_frame_n_out <= 1'b1;
						end
						else
						begin
							sclk_out <= ~sclk_out;
							tog_q    <= tog_q + 6'h01;
						end
					end
					else
						div_q <= div_q + 4'h1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			sclk_oe_out            <= 1'b0;
			receive_frame_n_oe_out <= 1'b0;
		end
		else
		begin
			sclk_oe_out            <= ~ss_q[1];
			receive_frame_n_oe_out <= ~ss_q[1];
		end
	end
endmodule

`default_nettype wire

/* File: adcsp_port_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module adcsp_port_sva (
	// system
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// pins
	input wire logic clock_source_select_in,
	input wire logic sclk_out,
	input wire logic sclk_oe_out,
	input wire logic receive_frame_n_in,
	input wire logic receive_frame_n_out,
	input wire logic receive_frame_n_oe_out,
	input wire logic data_oe_out,
	input wire logic sample_trigger_n_in,
	// events
	input wire logic sw_convert_out,
	input wire logic hw_convert_out,
	input wire logic self_clocking_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (reset_in);
	sequence s_high;
		sclk_out[*8] ##1 !sclk_out;
	endsequence
	sequence s_lead;
		##[6:10] $rose(sclk_out);
	endsequence
	chk_sclk_high: assert property ($rose(sclk_out) |-> s_high)
		else $error("serial clock high phase wrong");
	chk_sclk_low: assert property ($fell(sclk_out) |-> !sclk_out[*8])
		else $error("serial clock low phase short");
	chk_frame_len: assert property ($fell(receive_frame_n_out) |-> s_lead ##[250:262] $rose(receive_frame_n_out))
		else $error("frame length wrong");
	chk_clk_framed: assert property (receive_frame_n_out |-> !sclk_out)
		else $error("serial clock outside frame");
	chk_oe_mode: assert property (sclk_oe_out == self_clocking_out && receive_frame_n_oe_out == self_clocking_out)
		else $error("pin drive not matching mode");
	chk_mode_follow: assert property ($changed(clock_source_select_in) |-> ##[1:4] (self_clocking_out != clock_source_select_in))
		else $error("mode not following select");
	chk_oe_frame: assert property (receive_frame_n_in |-> !data_oe_out)
		else $error("data driven outside frame");
	chk_sw_pulse: assert property (sw_convert_out |=> !sw_convert_out)
		else $error("start pulse too long");
	chk_hw_pulse: assert property ($rose(sample_trigger_n_in) |-> ##[2:4] hw_convert_out)
		else $error("hardware start missing");
endmodule
`default_nettype wire

/* File: adcsp_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// host serial port
// ----------------------------------------------------------------
module adcsp_host (
	// link
	input  wire logic        link_clk_in,
	input  wire logic        frame_n_in,
	input  wire logic        rx_in,
	output var  logic        sclk_out,
	output var  logic        frame_n_out,
	output var  logic        tx_out,
	// words
	input  wire logic [4:0]  ctl_in,
	output var  logic [15:0] rx_word_out,
	output var  logic [7:0]  rx_cnt_out
);
	int k;
	initial
	begin
		sclk_out = 1'b0;
		frame_n_out = 1'b1;
		tx_out = 1'b0;
		rx_word_out = 16'h0000;
		rx_cnt_out = 8'h00;
		k = 0;
	end
	// one frame signal for read and write; with f high the clock runs with no frame, for link reset
	task automatic frame(input int n, input logic f);
		frame_n_out = f;
		#40;
		repeat (n)
		begin
			sclk_out = 1'b1;
			#80;
			sclk_out = 1'b0;
			#80;
		end
		#40 frame_n_out = 1'b1;
	endtask
	// word is held before the frame; msb first, later bits junk
	always @(posedge link_clk_in)
	begin
		if (!frame_n_in)
		begin
			tx_out <= (k < 5) ? ctl_in[4-k] : ~tx_out;
			k <= k + 1;
		end
	end
	always @(negedge link_clk_in)
	begin
		if (!frame_n_in)
			rx_word_out <= {rx_word_out[14:0], rx_in};
	end
	always @(posedge frame_n_in)
	begin
		if (k == 16)
			rx_cnt_out <= rx_cnt_out + 8'h01;
		k <= 0;
		tx_out <= ~tx_out;
	end
endmodule
`default_nettype wire

/* File: tb_adcsp_port.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_adcsp_port;
	logic        clk_sys_in, reset_in, sel, trig_n, rvalid, tog, stby;
	logic        sclk, sclk_oe, rf_n, rf_oe, dout, doe, rdy, swc, hwc, self_c;
	logic        h_sclk, h_frame, h_tx, sclk_w, frame_w, data_w;
	logic [11:0] rdat, w;
	logic [11:0] q[$];
	logic [4:0]  ctl, c;
	logic [2:0]  chan, ch;
	logic [15:0] h_rx;
	logic [7:0]  h_cnt;
	integer      seed = 32'h537d8c32;
	int          fails, num_checks, sw_n, hw_n, i, n0;
	// ----------------------------------------------------------------
	// wires and instances
	// ----------------------------------------------------------------
	assign sclk_w = sclk_oe ? sclk : h_sclk;
	assign frame_w = rf_oe ? rf_n : h_frame;
	assign data_w = doe ? dout : tog;
	adcsp_port dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .link_clk_in(sclk_w),
		.clock_source_select_in(sel), .sclk_out(sclk), .sclk_oe_out(sclk_oe),
		.receive_frame_n_in(frame_w), .receive_frame_n_out(rf_n), .receive_frame_n_oe_out(rf_oe),
		.transmit_frame_n_in(frame_w), .data_in(h_tx), .data_out(dout), .data_oe_out(doe),
		.sample_trigger_n_in(trig_n), .result_data_in(rdat), .result_valid_in(rvalid),
		.result_ready_out(rdy), .channel_out(chan), .standby_out(stby), .sw_convert_out(swc),
		.hw_convert_out(hwc), .self_clocking_out(self_c));
	adcsp_host host (.link_clk_in(sclk_w), .frame_n_in(frame_w), .rx_in(data_w), .sclk_out(h_sclk),
		.frame_n_out(h_frame), .tx_out(h_tx), .ctl_in(ctl), .rx_word_out(h_rx), .rx_cnt_out(h_cnt));
	initial
	begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in)
		tog <= ~tog;
	// pulses counted mid-cycle, where they are settled
	always @(negedge clk_sys_in)
	begin
		if (swc === 1'b1)
			sw_n++;
		if (hwc === 1'b1)
			hw_n++;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %0t seen %0h exp %0h", $time, seen, exp);
		end
	endtask
	task summarize();
		if (fails == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task push(input logic [11:0] d);
		logic seen_rdy;
		@(posedge clk_sys_in);
		#2 rdat = d;
		rvalid = 1'b1;
		// ready is registered, so its mid-cycle value is the one taken at the next edge
		do
		begin
			@(negedge clk_sys_in);
			seen_rdy = rdy;
			@(posedge clk_sys_in);
		end
		while (seen_rdy !== 1'b1);
		#2 rvalid = 1'b0;
	endtask
	task xfer(input logic [4:0] cw, input int n);
		ctl = cw;
		host.frame(n, 1'b0);
		repeat (12) @(posedge clk_sys_in);
		#2;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial
	begin
		{tog, reset_in, sel, trig_n, rvalid, rdat, ctl, ch} = {4'h7, 21'h000000};
		{fails, num_checks, sw_n, hw_n} = 0;
		// link reset needs link edges
		host.frame(4, 1'b1);
		repeat (3) @(posedge clk_sys_in);
		#2 reset_in = 1'b0;
		// link reset release also needs link edges before the first frame
		host.frame(4, 1'b1);
		for (i = 0; i < 5; i++)
		begin
			w = 12'($random(seed));
			q.push_back(w);
			push(w);
		end
		repeat (3) @(posedge clk_sys_in);
		#2 check(rdy, 1'b0);
		// drain, the last frame finds nothing staged
		for (i = 0; i < 6; i++)
		begin
			c = 5'($random(seed));
			c[1] = i[0];
			n0 = sw_n;
			xfer(c, 16);
			check(h_rx, {1'b0, ch, q[i < 5 ? i : 4]});
			check(chan, c[4:2]);
			check(stby, c[0]);
			check(sw_n - n0, c[1]);
			ch = c[4:2];
		end
		c = {~ch, 2'b10};
		n0 = sw_n;
		xfer(c, 5);
		check(chan, ch);
		check(sw_n - n0, 0);
		n0 = hw_n;
		trig_n = 1'b0;
		repeat (4) @(posedge clk_sys_in);
		#2 trig_n = 1'b1;
		repeat (8) @(posedge clk_sys_in);
		#2 check(hw_n - n0, 1);
		sel = 1'b0;
		repeat (6) @(posedge clk_sys_in);
		#2 check(self_c, 1'b1);
		check(sclk_oe, 1'b1);
		c = 5'($random(seed));
		ctl = c;
		w = 12'($random(seed));
		n0 = h_cnt;
		push(w);
		for (i = 0; i < 2000 && h_cnt == n0; i++)
			@(posedge clk_sys_in);
		repeat (12) @(posedge clk_sys_in);
		#2 check(h_rx, {1'b0, ch, w});
		check(h_cnt, 8'(n0 + 1));
		check(chan, c[4:2]);
		summarize();
	end
	initial
	begin
		#300000;
		fails++;
		summarize();
	end
endmodule
bind adcsp_port adcsp_port_sva chk (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
	.clock_source_select_in(clock_source_select_in), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out),
	.receive_frame_n_in(receive_frame_n_in), .receive_frame_n_out(receive_frame_n_out),
	.receive_frame_n_oe_out(receive_frame_n_oe_out), .data_oe_out(data_oe_out),
	.sample_trigger_n_in(sample_trigger_n_in), .sw_convert_out(sw_convert_out),
	.hw_convert_out(hw_convert_out), .self_clocking_out(self_clocking_out));
`default_nettype wire
